// ===== pcl_regs.svh
// register offsets, field positions and reset values of the clock/loopback control block
`ifndef PCL_REGS_SVH
`define PCL_REGS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define PCL_OFF_IRQ_SUMMARY 8'h02
`define PCL_OFF_CLK_MON 8'h04
`define PCL_OFF_MASTER 8'h05
`define PCL_OFF_TX_SYNTH 8'h06
`define PCL_OFF_RX_CDR 8'h07

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PCL_MON_RX_REF 3
`define PCL_MON_TX_REF 2
`define PCL_MON_RX_OUT 1
`define PCL_MON_TX_OUT 0
`define PCL_MC_LOC_IEN 7
`define PCL_MC_LOC 6
`define PCL_MC_FIXPTR 5
`define PCL_MC_LLOOP 2
`define PCL_MC_DLOOP 1
`define PCL_MC_LOOPT 0
`define PCL_CS_UNLOCK 3
`define PCL_CS_IEN 1
`define PCL_CS_REFSEL 0
`define PCL_IS_TX_UNLOCK 7
`define PCL_IS_LOC 6
`define PCL_IS_RX_UNLOCK 5

// ----------------------------------------------------------------------
// reset values, write masks, constants
// ----------------------------------------------------------------------
`define PCL_MASTER_RESET 8'h20
`define PCL_MASTER_WMASK 8'hA7
`define PCL_CS_RESET 8'h00
`define PCL_CS_WMASK 8'h03
// synchroniser idle pattern: the three active-low strobes sit high
`define PCL_SYNC_IDLE 29'h1C000000
`define PCL_FIXED_POINTER 10'h20A

`endif

// ===== pcl_pkg.sv
// types shared by the clock/loopback control block
package pcl_pkg;

  // ----------------------------------------------------------------------
  // transmit clock source
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PCL_SRC_TX_REF = 2'b00,
    PCL_SRC_RECOVERED = 2'b01,
    PCL_SRC_RX_REF = 2'b10
  } pcl_tx_src_t;

  // ----------------------------------------------------------------------
  // control levels toward the datapath and analog blocks
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic fixed_pointer;
    logic line_loopback;
    logic diagnostic_loopback;
    logic loop_timing_enable;
    logic tx_reference_frequency_select;
    logic rx_reference_frequency_select;
  } pcl_ctrl_t;

  // ----------------------------------------------------------------------
  // synchronised microprocessor access
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcl_cpu_t;

endpackage : pcl_pkg

// ===== pcl_ctrl.sv
// clock activity monitors, master control and PLL control/status registers
`timescale 1ns/1ps
`include "pcl_regs.svh"

module pcl_ctrl (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // microprocessor port
  input wire logic cpu_cs_n_i,
  input wire logic cpu_rd_n_i,
  input wire logic cpu_wr_n_i,
  input wire logic [7:0] cpu_addr_i,
  input wire logic [7:0] cpu_data_i,
  output logic [7:0] cpu_data_o,
  output logic cpu_data_oe_o,
  output logic interrupt_output_n_o,
  // monitored clocks
  input wire logic rx_reference_clock_i,
  input wire logic tx_reference_clock_i,
  input wire logic rx_output_clock_i,
  input wire logic tx_output_clock_i,
  // status from datapath and analog blocks
  input wire logic cell_delineation_lost_i,
  input wire logic tx_synth_unlocked_i,
  input wire logic rx_freq_deviation_i,
  input wire logic rx_no_transitions_i,
  input wire logic rx_recovery_bypass_i,
  input wire logic tx_synth_bypass_i,
  // control toward datapath and analog blocks
  output pcl_pkg::pcl_ctrl_t ctrl_o,
  output pcl_pkg::pcl_tx_src_t tx_clock_source_o,
  output logic [9:0] payload_pointer_o,
  output logic pointer_adjust_enable_o,
  output logic tx_synth_ref_low_o,
  output logic rx_recovery_ref_low_o
);
  import pcl_pkg::*;

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  localparam int NSYNC = 29;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [3:0] clk_prev;

  // strobes are synchronised raw and combined after, so pin skew cannot glitch them
  assign raw_in = {cpu_cs_n_i, cpu_rd_n_i, cpu_wr_n_i, cpu_addr_i, cpu_data_i,
                   rx_reference_clock_i, tx_reference_clock_i, rx_output_clock_i,
                   tx_output_clock_i, cell_delineation_lost_i, tx_synth_unlocked_i,
                   rx_freq_deviation_i, rx_no_transitions_i, rx_recovery_bypass_i,
                   tx_synth_bypass_i};

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_a <= `PCL_SYNC_IDLE;
      sync_b <= `PCL_SYNC_IDLE;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  pcl_cpu_t cpu;
  logic [3:0] clk_s;
  logic loc_s;
  logic tx_unlock_s;
  logic rx_unlock_s;
  logic rx_recovery_bypass_s;
  logic tx_synth_bypass_s;

  assign cpu = {~sync_b[28] & ~sync_b[27], ~sync_b[28] & ~sync_b[26], sync_b[25:10]};
  assign clk_s = sync_b[9:6];
  assign loc_s = sync_b[5];
  assign tx_unlock_s = sync_b[4];
  // the analog recovery loop reports each loss cause; either one is out of lock
  assign rx_unlock_s = sync_b[3] | sync_b[2];
  assign rx_recovery_bypass_s = sync_b[1];
  assign tx_synth_bypass_s = sync_b[0];

  // ----------------------------------------------------------------------
  // access strobes
  // ----------------------------------------------------------------------
  logic rd_q;
  logic wr_q;
  logic rd_start;
  logic wr_start;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      rd_q <= cpu.rd;
      wr_q <= cpu.wr;
    end
  end

  // one access acts once, at the first cycle its synchronised strobe is seen
  assign rd_start = cpu.rd & ~rd_q;
  assign wr_start = cpu.wr & ~wr_q;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  // ----------------------------------------------------------------------
  // clock activity monitors
  // ----------------------------------------------------------------------
  // a 10 MHz core only sees that a faster clock toggles, not its frequency
  logic [3:0] clk_edge;
  logic [3:0] mon_flag;
  logic mon_clear;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clk_prev <= '0;
    end else begin
      clk_prev <= clk_s;
    end
  end

  assign mon_clear = rd_start & hit(cpu.addr, `PCL_OFF_CLK_MON);

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_mon
      assign clk_edge[g] = clk_s[g] & ~clk_prev[g];
      always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          mon_flag[g] <= 1'b0;
        end else begin
          mon_flag[g] <= (mon_flag[g] & ~mon_clear) | clk_edge[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  logic [7:0] master;
  logic [7:0] tx_cs;
  logic [7:0] rx_cs;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      master <= `PCL_MASTER_RESET;
    end else if (wr_start && hit(cpu.addr, `PCL_OFF_MASTER)) begin
      master <= cpu.wdata & `PCL_MASTER_WMASK;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_cs <= `PCL_CS_RESET;
    end else if (wr_start && hit(cpu.addr, `PCL_OFF_TX_SYNTH)) begin
      tx_cs <= cpu.wdata & `PCL_CS_WMASK;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_cs <= `PCL_CS_RESET;
    end else if (wr_start && hit(cpu.addr, `PCL_OFF_RX_CDR)) begin
      rx_cs <= cpu.wdata & `PCL_CS_WMASK;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt flags
  // ----------------------------------------------------------------------
  logic loc_q;
  logic tx_unlock_q;
  logic rx_unlock_q;
  logic tx_unlock_irq_flag;
  logic rx_unlock_irq_flag;
  logic delineation_change_irq_flag;
  logic is_clear;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      loc_q <= 1'b0;
      tx_unlock_q <= 1'b0;
      rx_unlock_q <= 1'b0;
    end else begin
      loc_q <= loc_s;
      tx_unlock_q <= tx_unlock_s;
      rx_unlock_q <= rx_unlock_s;
    end
  end

  assign is_clear = rd_start & hit(cpu.addr, `PCL_OFF_IRQ_SUMMARY);

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_unlock_irq_flag <= 1'b0;
      rx_unlock_irq_flag <= 1'b0;
      delineation_change_irq_flag <= 1'b0;
    end else begin
      tx_unlock_irq_flag <= (tx_unlock_irq_flag & ~is_clear) | (tx_unlock_s & ~tx_unlock_q);
      rx_unlock_irq_flag <= (rx_unlock_irq_flag & ~is_clear) | (rx_unlock_s & ~rx_unlock_q);
      delineation_change_irq_flag <= (delineation_change_irq_flag & ~is_clear)
                                     | (loc_s ^ loc_q);
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      interrupt_output_n_o <= 1'b1;
    end else begin
      interrupt_output_n_o <= ~((delineation_change_irq_flag & master[`PCL_MC_LOC_IEN])
                              | (tx_unlock_irq_flag & tx_cs[`PCL_CS_IEN])
                              | (rx_unlock_irq_flag & rx_cs[`PCL_CS_IEN]));
    end
  end

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  logic [7:0] rd_value;

  always_comb begin
    rd_value = 8'h00;
    unique case (cpu.addr)
      `PCL_OFF_IRQ_SUMMARY: begin
        rd_value[`PCL_IS_TX_UNLOCK] = tx_unlock_irq_flag;
        rd_value[`PCL_IS_LOC] = delineation_change_irq_flag;
        rd_value[`PCL_IS_RX_UNLOCK] = rx_unlock_irq_flag;
      end
      `PCL_OFF_CLK_MON: rd_value[3:0] = mon_flag;
      `PCL_OFF_MASTER: begin
        rd_value = master;
        rd_value[`PCL_MC_LOC] = loc_s;
      end
      `PCL_OFF_TX_SYNTH: begin
        rd_value = tx_cs;
        rd_value[`PCL_CS_UNLOCK] = tx_unlock_s;
      end
      `PCL_OFF_RX_CDR: begin
        rd_value = rx_cs;
        rd_value[`PCL_CS_UNLOCK] = rx_unlock_s;
      end
      default: rd_value = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cpu_data_o <= 8'h00;
    end else if (rd_start) begin
      cpu_data_o <= rd_value;
    end
  end

  // drive only once the captured value is on the flops
  assign cpu_data_oe_o = cpu.rd & rd_q;

  // ----------------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------------
  assign ctrl_o.fixed_pointer = master[`PCL_MC_FIXPTR];
  assign ctrl_o.line_loopback = master[`PCL_MC_LLOOP];
  assign ctrl_o.diagnostic_loopback = master[`PCL_MC_DLOOP];
  assign ctrl_o.loop_timing_enable = master[`PCL_MC_LOOPT];
  assign ctrl_o.tx_reference_frequency_select = tx_cs[`PCL_CS_REFSEL];
  assign ctrl_o.rx_reference_frequency_select = rx_cs[`PCL_CS_REFSEL];

  assign payload_pointer_o = `PCL_FIXED_POINTER;
  assign pointer_adjust_enable_o = ~master[`PCL_MC_FIXPTR];

  // a bypassed loop takes its rate from the pin, so the select is moot
  assign tx_synth_ref_low_o = tx_cs[`PCL_CS_REFSEL] & ~tx_synth_bypass_s;
  assign rx_recovery_ref_low_o = rx_cs[`PCL_CS_REFSEL] & ~rx_recovery_bypass_s;

  always_comb begin
    if (!master[`PCL_MC_LOOPT]) begin
      tx_clock_source_o = PCL_SRC_TX_REF;
    end else if (rx_recovery_bypass_s) begin
      tx_clock_source_o = PCL_SRC_RX_REF;
    end else begin
      tx_clock_source_o = PCL_SRC_RECOVERED;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  logic rst_seen;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_seen <= 1'b0;
    end else begin
      rst_seen <= 1'b1;
    end
  end

  a_rx_ref_mon: assert property (clk_edge[3] |=> mon_flag[3])
    else $error("rx reference monitor flag not set");
  a_tx_out_mon: assert property (mon_clear && !clk_edge[0] |=> !mon_flag[0])
    else $error("tx output monitor flag not cleared by read");
  a_loc_irq: assert property (delineation_change_irq_flag && master[7] |=> !interrupt_output_n_o)
    else $error("delineation change did not raise interrupt");
  a_loc_readback: assert property (rd_start && cpu.addr == 8'h05 |=> cpu_data_o[6] == $past(loc_s))
    else $error("master read does not show delineation lost");
  a_fixed_ptr: assert property (master[5] |-> payload_pointer_o == 10'h20A && !pointer_adjust_enable_o)
    else $error("fixed pointer not held");
  a_loop_src: assert property (master[0] && !rx_recovery_bypass_s |-> tx_clock_source_o == PCL_SRC_RECOVERED)
    else $error("loop timing source wrong");
  a_master_reset: assert property (!rst_seen |-> master == 8'h20 && tx_cs == 8'h00)
    else $error("control reset value wrong");
  a_tx_unlock_rd: assert property (rd_start && cpu.addr == 8'h06 |=> cpu_data_o[3] == $past(tx_unlock_s))
    else $error("tx unlocked status wrong");
  a_set_wins: assert property (is_clear && (loc_s != loc_q) |=> delineation_change_irq_flag)
    else $error("event lost during clearing read");
  a_irq_release: assert property (!tx_unlock_irq_flag && !rx_unlock_irq_flag
                                  && !delineation_change_irq_flag |=> interrupt_output_n_o)
    else $error("interrupt held with no flag");

  c_read_clear: cover property (mon_flag[1] ##1 mon_clear ##1 !mon_flag[1]);
  c_tx_unlock_irq: cover property (tx_cs[1] && tx_unlock_irq_flag ##1 !interrupt_output_n_o);
  c_loop_rx_ref: cover property (tx_clock_source_o == PCL_SRC_RX_REF);

endmodule : pcl_ctrl

// ===== pcl_ctrl_bench.sv
// self-checking testbench of the clock/loopback control block
`timescale 1ns/1ps
`include "pcl_regs.svh"

`define CHK(got, exp) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); \
  end \
end

module pcl_ctrl_bench;
  import pcl_pkg::*;

  // ----------------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------------
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  // {rx ref, tx ref, rx out, tx out}
  logic [3:0] mon_clk = 4'h0;
  logic cell_delineation_lost = 1'b0;
  logic tx_unl = 1'b0;
  // {no transitions, frequency deviation}
  logic [1:0] rx_cause = 2'h0;
  logic rx_byp = 1'b0;
  logic tx_byp = 1'b0;
  logic [7:0] rdata;
  logic oe;
  logic irq_n;
  pcl_ctrl_t ctrl;
  pcl_tx_src_t src;
  logic [9:0] ptr;
  logic ptr_adj;
  logic tx_low;
  logic rx_low;
  logic [7:0] d;
  int error_cnt = 0;
  int cmp_count = 0;

  always #50 clk = ~clk;

  pcl_ctrl dut_u (
    .core_clk_i(clk),
    .resetn_i(resetn),
    .cpu_cs_n_i(cs_n),
    .cpu_rd_n_i(rd_n),
    .cpu_wr_n_i(wr_n),
    .cpu_addr_i(addr),
    .cpu_data_i(wdata),
    .cpu_data_o(rdata),
    .cpu_data_oe_o(oe),
    .interrupt_output_n_o(irq_n),
    .rx_reference_clock_i(mon_clk[3]),
    .tx_reference_clock_i(mon_clk[2]),
    .rx_output_clock_i(mon_clk[1]),
    .tx_output_clock_i(mon_clk[0]),
    .cell_delineation_lost_i(cell_delineation_lost),
    .tx_synth_unlocked_i(tx_unl),
    .rx_freq_deviation_i(rx_cause[0]),
    .rx_no_transitions_i(rx_cause[1]),
    .rx_recovery_bypass_i(rx_byp),
    .tx_synth_bypass_i(tx_byp),
    .ctrl_o(ctrl),
    .tx_clock_source_o(src),
    .payload_pointer_o(ptr),
    .pointer_adjust_enable_o(ptr_adj),
    .tx_synth_ref_low_o(tx_low),
    .rx_recovery_ref_low_o(rx_low)
  );

  // ----------------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  // strobes are synchronised inside, so every phase lasts at least 3 cycles
  task automatic cpu_wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    addr = a;
    wdata = v;
    tick(3);
    cs_n = 1'b0;
    wr_n = 1'b0;
    tick(4);
    cs_n = 1'b1;
    wr_n = 1'b1;
    tick(4);
  endtask : cpu_wr

  task automatic cpu_rd(input logic [7:0] a, output logic [7:0] v);
    int n;
    n = 0;
    @(negedge clk);
    addr = a;
    tick(3);
    cs_n = 1'b0;
    rd_n = 1'b0;
    while (oe !== 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    `CHK(oe, 1'b1)
    tick(1);
    v = rdata;
    cs_n = 1'b1;
    rd_n = 1'b1;
    tick(5);
  endtask : cpu_rd

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    cpu_rd(a, v);
    `CHK(v, e)
  endtask : rd_chk

  // each level lasts 3 cycles so the 2-flop sampler sees the edge
  task automatic pulse(input int i);
    mon_clk[i] = 1'b1;
    tick(3);
    mon_clk[i] = 1'b0;
    tick(3);
  endtask : pulse

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    tick(2);
    `CHK(irq_n, 1'b1)
    `CHK(ctrl, 6'h20)
    `CHK(ptr, 10'h20A)
    `CHK(ptr_adj, 1'b0)
    `CHK(src, PCL_SRC_TX_REF)
    rd_chk(`PCL_OFF_MASTER, 8'h20);
    rd_chk(`PCL_OFF_TX_SYNTH, 8'h00);
    rd_chk(`PCL_OFF_RX_CDR, 8'h00);
    rd_chk(8'h33, 8'h00);
    $display("test reset done");
    cpu_rd(`PCL_OFF_CLK_MON, d);
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      rd_chk(`PCL_OFF_CLK_MON, 8'h01 << i);
      rd_chk(`PCL_OFF_CLK_MON, 8'h00);
    end
    $display("test monitors done");
    cpu_wr(`PCL_OFF_MASTER, 8'hFF);
    rd_chk(`PCL_OFF_MASTER, 8'hA7);
    `CHK(ctrl, 6'h3C)
    cpu_wr(`PCL_OFF_MASTER, 8'h00);
    `CHK(ctrl, 6'h00)
    `CHK(ptr_adj, 1'b1)
    cell_delineation_lost = 1'b1;
    cpu_wr(`PCL_OFF_MASTER, 8'h18);
    rd_chk(`PCL_OFF_MASTER, 8'h40);
    cell_delineation_lost = 1'b0;
    tick(4);
    rd_chk(`PCL_OFF_MASTER, 8'h00);
    $display("test master done");
    cpu_wr(`PCL_OFF_MASTER, 8'h01);
    `CHK(src, PCL_SRC_RECOVERED)
    rx_byp = 1'b1;
    tick(4);
    `CHK(src, PCL_SRC_RX_REF)
    cpu_wr(`PCL_OFF_MASTER, 8'h00);
    `CHK(src, PCL_SRC_TX_REF)
    rx_byp = 1'b0;
    $display("test loop timing done");
    cpu_wr(`PCL_OFF_TX_SYNTH, 8'hFD);
    rd_chk(`PCL_OFF_TX_SYNTH, 8'h01);
    `CHK(tx_low, 1'b1)
    tx_byp = 1'b1;
    tick(4);
    `CHK(tx_low, 1'b0)
    tx_byp = 1'b0;
    cpu_wr(`PCL_OFF_RX_CDR, 8'hFD);
    rd_chk(`PCL_OFF_RX_CDR, 8'h01);
    `CHK(rx_low, 1'b1)
    `CHK(ctrl, 6'h03)
    rx_byp = 1'b1;
    tick(4);
    `CHK(rx_low, 1'b0)
    rx_byp = 1'b0;
    cpu_wr(`PCL_OFF_TX_SYNTH, 8'h00);
    cpu_wr(`PCL_OFF_RX_CDR, 8'h00);
    $display("test reference select done");
    // clear the delineation change flags left by the master test
    cpu_rd(`PCL_OFF_IRQ_SUMMARY, d);
    tx_unl = 1'b1;
    tick(4);
    rd_chk(`PCL_OFF_TX_SYNTH, 8'h08);
    `CHK(irq_n, 1'b1)
    cpu_wr(`PCL_OFF_TX_SYNTH, 8'h02);
    tick(3);
    `CHK(irq_n, 1'b0)
    rd_chk(`PCL_OFF_IRQ_SUMMARY, 8'h80);
    `CHK(irq_n, 1'b1)
    rd_chk(`PCL_OFF_IRQ_SUMMARY, 8'h00);
    tx_unl = 1'b0;
    tick(4);
    rd_chk(`PCL_OFF_TX_SYNTH, 8'h02);
    cpu_wr(`PCL_OFF_TX_SYNTH, 8'h00);
    $display("test tx unlock done");
    for (int j = 0; j < 2; j++) begin
      rx_cause[j] = 1'b1;
      tick(4);
      rd_chk(`PCL_OFF_RX_CDR, 8'h08);
      `CHK(irq_n, 1'b1)
      rx_cause[j] = 1'b0;
      tick(4);
      rd_chk(`PCL_OFF_RX_CDR, 8'h00);
      rd_chk(`PCL_OFF_IRQ_SUMMARY, 8'h20);
    end
    cpu_wr(`PCL_OFF_RX_CDR, 8'h02);
    rx_cause[0] = 1'b1;
    tick(6);
    `CHK(irq_n, 1'b0)
    rd_chk(`PCL_OFF_IRQ_SUMMARY, 8'h20);
    `CHK(irq_n, 1'b1)
    rx_cause[0] = 1'b0;
    cpu_wr(`PCL_OFF_RX_CDR, 8'h00);
    $display("test rx unlock done");
    cpu_wr(`PCL_OFF_MASTER, 8'h80);
    for (int k = 0; k < 2; k++) begin
      cell_delineation_lost = ~cell_delineation_lost;
      tick(6);
      `CHK(irq_n, 1'b0)
      rd_chk(`PCL_OFF_IRQ_SUMMARY, 8'h40);
      `CHK(irq_n, 1'b1)
    end
    // flip the status in the very cycle the clearing read takes effect
    fork
      cpu_rd(`PCL_OFF_IRQ_SUMMARY, d);
      begin
        tick(4);
        cell_delineation_lost = ~cell_delineation_lost;
      end
    join
    `CHK(d, 8'h00)
    `CHK(irq_n, 1'b0)
    rd_chk(`PCL_OFF_IRQ_SUMMARY, 8'h40);
    $display("test delineation done");
    test_done;
  end

  // ----------------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("unexpected at %0t: got %0h expected %0h", $time, 1'b0, 1'b1);
    test_done;
  end

endmodule : pcl_ctrl_bench
